// *** inc/dio_pkg.sv ***
// Shared constants, register map and line kinds of the digital line control block.
package dio_pkg;

  typedef enum logic [1:0] {dio_bidir, dio_in_only, dio_out_only} dio_kind_type;

  localparam int NUM_LINES = 12;
  localparam int NUM_PINS  = 5;
  localparam int NUM_LINK  = 2;
  localparam int NUM_CC    = 4;
  localparam int NUM_ASYNC = NUM_PINS + NUM_CC;
  localparam int SEL_W     = 4;
  localparam int UO_W      = 8;
  localparam int PICK_W    = 3;
  localparam int SRC_W     = 4;
  localparam int ADDR_W    = 8;

  // Line index map.
  localparam int LINE_IN_ONLY  = 4;
  localparam int LINE_OUT_ONLY = 5;
  localparam int NUM_DRIVEN    = 6;
  localparam int LINK_BASE     = 6;
  localparam int CC_BASE       = 8;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_LINE_SEL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LINE_DIR   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LINE_INV   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LINE_LEVEL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_LINE_ALL   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LINE_SRC   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_UO_PICK    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_UO_VALUE   = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_UO_WORD    = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_UO_MASK    = 8'h24;

  // Output source codes.
  localparam logic [SRC_W-1:0] SRC_OFF     = 4'h0;
  localparam logic [SRC_W-1:0] SRC_TIMER   = 4'h1;
  localparam logic [SRC_W-1:0] SRC_EXPO    = 4'h2;
  localparam logic [SRC_W-1:0] SRC_UO_BASE = 4'h8;

  // Reset values.
  localparam logic [UO_W-1:0] UO_RST   = 8'h00;
  localparam logic [UO_W-1:0] MASK_RST = 8'hff;
  localparam logic            DIR_IN   = 1'b0;
  localparam logic            DIR_OUT  = 1'b1;

  function automatic dio_kind_type dio_kind(input int idx);
    if (idx == LINE_OUT_ONLY)
      return dio_out_only;
    else if (idx < LINE_IN_ONLY)
      return dio_bidir;
    else
      return dio_in_only;
  endfunction

endpackage

// *** rtl/dio_sync.sv ***
// Three-flop input synchroniser with agreement filter on the last two stages.
module dio_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      sync_out
);
  import dio_pkg::*;

  logic meta;
  logic stage2;
  logic stage3;

  // The first flop feeds only the second; the filter looks at stages two and three.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta     <= 1'b0;
      stage2   <= 1'b0;
      stage3   <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta   <= async_in;
      stage2 <= meta;
      stage3 <= stage2;
      if (stage2 == stage3)
        sync_out <= stage3;
    end
  end

endmodule

// *** rtl/dio_line_cell.sv ***
// Conditioning path of one line: source choice, inversion, driver enable and level.
module dio_line_cell #(
  parameter dio_pkg::dio_kind_type KIND = dio_pkg::dio_bidir
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      line_in,
  input  wire logic                      is_output,
  input  wire logic                      invert,
  input  wire logic [dio_pkg::SRC_W-1:0] origin,
  input  wire logic [dio_pkg::UO_W-1:0]  soft_out,
  input  wire logic                      timer_running_signal,
  input  wire logic                      exposure_in_progress_signal,
  output logic                           line_out,
  output logic                           line_oe,
  output logic                           level
);
  import dio_pkg::*;

  logic picked;
  logic drive;
  logic next_out;

  always_comb
  begin
    picked = 1'b0;
    if (origin == SRC_TIMER)
      picked = timer_running_signal;
    else if (origin == SRC_EXPO)
      picked = exposure_in_progress_signal;
    else if (origin >= SRC_UO_BASE)
      picked = soft_out[PICK_W'(origin - SRC_UO_BASE)];
    drive    = (KIND != dio_in_only) && is_output && (origin != SRC_OFF);
    next_out = drive & (picked ^ invert);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_out <= 1'b0;
      line_oe  <= 1'b0;
      level    <= 1'b0;
    end
    else
    begin
      line_out <= next_out;
      line_oe  <= drive;
      // An output-only line has no receiver, so its level is its own driven value seen through the inverter.
      if (KIND == dio_out_only)
        level <= next_out ^ invert;
      else
        level <= line_in ^ invert;
    end
  end

endmodule

// *** rtl/dio_line_ctrl.sv ***
// Digital line control block: APB registers, per-line configuration and soft output word.
//
// Contract
// - Software sets each bidirectional line's direction.
// - Bidirectional lines reset to input.
// - Inversion applies to inputs and outputs alike.
// - Level readable in either direction.
// - Level sampled after the input inverter.
// - Level reads one for high, zero low.
// - All levels in one word, line0 lsb.
// - Output lines drive the chosen internal signal.
// - Any soft output bit selectable as source.
// - Single soft bit set by pick and value.
// - Whole soft word written in one access.
// - Per-line settings act on selected line only.
// - Selector reaches pins, link and control lines.
// - Input-only lines report input, read-only.
// - Output-only lines report output, read-only.
// - Fixed lines keep settings read-only; direction is fixed but inversion and line 5's source stay writable.
// - Source matters only when line is output.
// - Source off disables the driver.
// - Word bit zero is soft bit zero.
// - Mask limits which soft bits change; only word writes use it, single-bit value writes ignore it.
//
// The address map and register access over APB were left to the implementer.
module dio_line_ctrl (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [dio_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  input  wire logic [dio_pkg::NUM_PINS-1:0]  pin_in,
  output logic [dio_pkg::NUM_DRIVEN-1:0]     pin_out,
  output logic [dio_pkg::NUM_DRIVEN-1:0]     pin_oe,
  input  wire logic [dio_pkg::NUM_LINK-1:0]  transport_virtual_trigger_line,
  input  wire logic [dio_pkg::NUM_CC-1:0]    camera_control_line,
  input  wire logic                          timer_running_signal,
  input  wire logic                          exposure_in_progress_signal
);
  import dio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [NUM_ASYNC-1:0] async_pins;
  logic [NUM_ASYNC-1:0] synced_pins;
  logic [NUM_LINES-1:0] line_raw;
  logic [NUM_LINES-1:0] line_level;
  logic [NUM_LINES-1:0] cell_out;
  logic [NUM_LINES-1:0] cell_oe;

  logic                 line_dir [NUM_LINES];
  logic                 line_inv [NUM_LINES];
  logic [SRC_W-1:0]     line_src [NUM_LINES];

  logic [SEL_W-1:0]     line_index_select;
  logic                 sel_valid;
  logic [UO_W-1:0]      soft_output_word;
  logic [UO_W-1:0]      soft_output_write_mask;
  logic [PICK_W-1:0]    soft_output_bit_pick;

  logic                 access;
  logic                 wr_go;
  logic                 next_pready;
  logic [31:0]          next_prdata;
  logic                 next_pslverr;

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisation and line assembly.

  assign async_pins = {camera_control_line, pin_in};

  generate
    for (genvar p = 0; p < NUM_ASYNC; p++)
    begin : g_sync
      dio_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (async_pins[p]),
        .sync_out (synced_pins[p])
      );
    end
  endgenerate

  // The transport trigger lines come from on-chip logic on this clock, so they need no synchroniser.
  always_comb
  begin
    line_raw = '0;
    line_raw[NUM_PINS-1:0] = synced_pins[NUM_PINS-1:0];
    line_raw[LINK_BASE +: NUM_LINK] = transport_virtual_trigger_line;
    line_raw[CC_BASE +: NUM_CC] = synced_pins[NUM_PINS +: NUM_CC];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait state, write commits at the edge that sees pready.

  assign access      = psel & penable;
  assign wr_go       = access & pready & pwrite;
  assign next_pready = access & ~pready;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= next_pready;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line selector.

  assign sel_valid = (line_index_select < SEL_W'(NUM_LINES));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      line_index_select <= '0;
    else if (wr_go && paddr == OFS_LINE_SEL)
      line_index_select <= pwdata[SEL_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-line settings; each line's fields are written only while it is selected.

  generate
    for (genvar i = 0; i < NUM_LINES; i++)
    begin : g_cfg
      localparam dio_kind_type KIND = dio_kind(i);
      localparam logic         DIR_RST = (KIND == dio_out_only) ? DIR_OUT : DIR_IN;
      logic                    hit;

      assign hit = wr_go && (line_index_select == SEL_W'(i));

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          line_dir[i] <= DIR_RST;
        else if (hit && paddr == OFS_LINE_DIR && KIND == dio_bidir)
          line_dir[i] <= pwdata[0];
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          line_inv[i] <= 1'b0;
        else if (hit && paddr == OFS_LINE_INV)
          line_inv[i] <= pwdata[0];
      end

      // Input-only lines have no source, so writes there are dropped and the field reads as off.
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          line_src[i] <= SRC_OFF;
        else if (hit && paddr == OFS_LINE_SRC && KIND != dio_in_only)
          line_src[i] <= pwdata[SRC_W-1:0];
      end

      dio_line_cell #(
        .KIND (KIND)
      ) u_cell (
        .pclk                        (pclk),
        .presetn                     (presetn),
        .line_in                     (line_raw[i]),
        .is_output                   (line_dir[i]),
        .invert                      (line_inv[i]),
        .origin                      (line_src[i]),
        .soft_out                    (soft_output_word),
        .timer_running_signal        (timer_running_signal),
        .exposure_in_progress_signal (exposure_in_progress_signal),
        .line_out                    (cell_out[i]),
        .line_oe                     (cell_oe[i]),
        .level                       (line_level[i])
      );
    end
  endgenerate

  // Only the physical lines reach pins; the flops sit inside the cells.
  assign pin_out = cell_out[NUM_DRIVEN-1:0];
  assign pin_oe  = cell_oe[NUM_DRIVEN-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Soft output word, its single-bit pick and its write mask.

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      soft_output_bit_pick <= '0;
    else if (wr_go && paddr == OFS_UO_PICK)
      soft_output_bit_pick <= pwdata[PICK_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      soft_output_write_mask <= MASK_RST;
    else if (wr_go && paddr == OFS_UO_MASK)
      soft_output_write_mask <= pwdata[UO_W-1:0];
  end

  // A masked word write and a single-bit write cannot meet: they sit at different addresses.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      soft_output_word <= UO_RST;
    else if (wr_go && paddr == OFS_UO_VALUE)
      soft_output_word[soft_output_bit_pick] <= pwdata[0];
    else if (wr_go && paddr == OFS_UO_WORD)
      soft_output_word <= (soft_output_word & ~soft_output_write_mask)
                        | (pwdata[UO_W-1:0] & soft_output_write_mask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path: data are latched together with pready.

  always_comb
  begin
    next_prdata  = '0;
    next_pslverr = 1'b0;
    case (paddr)
      OFS_LINE_SEL:
        next_prdata[SEL_W-1:0] = line_index_select;
      OFS_LINE_DIR:
      begin
        if (sel_valid)
          next_prdata[0] = line_dir[line_index_select];
      end
      OFS_LINE_INV:
      begin
        if (sel_valid)
          next_prdata[0] = line_inv[line_index_select];
      end
      OFS_LINE_LEVEL:
      begin
        if (sel_valid)
          next_prdata[0] = line_level[line_index_select];
      end
      OFS_LINE_ALL:
        next_prdata[NUM_LINES-1:0] = line_level;
      OFS_LINE_SRC:
      begin
        if (sel_valid)
          next_prdata[SRC_W-1:0] = line_src[line_index_select];
      end
      OFS_UO_PICK:
        next_prdata[PICK_W-1:0] = soft_output_bit_pick;
      OFS_UO_VALUE:
        next_prdata[0] = soft_output_word[soft_output_bit_pick];
      OFS_UO_WORD:
        next_prdata[UO_W-1:0] = soft_output_word;
      OFS_UO_MASK:
        next_prdata[UO_W-1:0] = soft_output_write_mask;
      default:
        next_pslverr = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (next_pready)
    begin
      prdata  <= pwrite ? '0 : next_prdata;
      pslverr <= next_pslverr;
    end
    else
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
  end

endmodule

// *** testbench/dio_line_ctrl_properties.sv ***
// Port checker of the digital line control block.
module dio_line_ctrl_properties
  import dio_pkg::*;
(
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [dio_pkg::ADDR_W-1:0]    paddr,
  input wire logic                          pready,
  input wire logic [31:0]                   prdata,
  input wire logic                          pslverr,
  input wire logic [dio_pkg::NUM_DRIVEN-1:0] pin_out,
  input wire logic [dio_pkg::NUM_DRIVEN-1:0] pin_oe,
  input wire logic                          timer_running_signal,
  input wire logic                          exposure_in_progress_signal
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [1:0] wr_age;
  logic [1:0] src_age;
  logic [1:0] src_prev;
  // Ages saturate at three, so an output change must follow its cause closely.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      wr_age <= 2'h3;
    else if (psel && penable && pready && pwrite)
      wr_age <= 2'h0;
    else if (wr_age != 2'h3)
      wr_age <= wr_age + 2'h1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      src_age  <= 2'h3;
      src_prev <= 2'h0;
    end
    else
    begin
      src_prev <= {timer_running_signal, exposure_in_progress_signal};
      if ({timer_running_signal, exposure_in_progress_signal} != src_prev)
        src_age <= 2'h0;
      else if (src_age != 2'h3)
        src_age <= src_age + 2'h1;
    end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  rst_quiet_a: assert property ($rose(presetn) |-> pin_oe == 6'h00 && !pready)
    else $error("outputs active right after reset");
  in_only_off_a: assert property (pin_oe[LINE_IN_ONLY] == 1'b0)
    else $error("input-only line driven");
  one_line_a: assert property ($onehot0(pin_oe ^ $past(pin_oe)))
    else $error("several drivers changed at once");
  oe_by_write_a: assert property ($changed(pin_oe) |-> wr_age < 2'h3)
    else $error("driver enable changed without a write");
  out_cause_a: assert property ($changed(pin_out) |-> wr_age < 2'h3 || src_age < 2'h3)
    else $error("line output changed without a cause");
  lvl_width_a: assert property (pready && !pwrite && paddr == OFS_LINE_LEVEL |-> prdata[31:1] == 31'h0)
    else $error("level read wider than one bit");
  all_width_a: assert property (pready && !pwrite && paddr == OFS_LINE_ALL |-> prdata[31:12] == 20'h0)
    else $error("level word has bits above the last line");
  unmapped_err_a: assert property (pready && paddr > OFS_UO_MASK |-> pslverr)
    else $error("unmapped access not refused");
  access_answer_a: assert property (setup_s ##1 access_s |=> pready)
    else $error("no answer in second access cycle");
  idle_quiet_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0 && (pready || !pslverr))
    else $error("read data or error outside a read answer");
endmodule

bind dio_line_ctrl dio_line_ctrl_properties i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
  .prdata, .pslverr, .pin_out, .pin_oe, .timer_running_signal, .exposure_in_progress_signal);

// *** testbench/dio_pin_model.sv ***
// Connector wiring: far-side drivers meet the block's drivers on lines 0 to 4.
module dio_pin_model (
  input wire logic [dio_pkg::NUM_DRIVEN-1:0] pin_out,
  input wire logic [dio_pkg::NUM_DRIVEN-1:0] pin_oe,
  input wire logic [dio_pkg::NUM_PINS-1:0]   ext_level,
  output logic [dio_pkg::NUM_PINS-1:0]       pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import dio_pkg::*;
  // The far side backs off while the block drives, so a driven line reads back its own level.
  always_comb
    for (int i = 0; i < NUM_PINS; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
endmodule

// *** testbench/dio_line_ctrl_tb_top.sv ***
// Self-checking bench of the digital line control block.
module dio_line_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dio_pkg::*;
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, timer, expo;
  logic [ADDR_W-1:0]     paddr;
  logic [31:0]           pwdata, prdata, q;
  logic [NUM_PINS-1:0]   pin_in, ext_level;
  logic [NUM_DRIVEN-1:0] pin_out, pin_oe;
  logic [NUM_LINK-1:0]   link;
  logic [NUM_CC-1:0]     cc;
  int                    miscompares, tests_run;
  dio_line_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .pin_in, .pin_out, .pin_oe, .transport_virtual_trigger_line(link), .camera_control_line(cc),
    .timer_running_signal(timer), .exposure_in_progress_signal(expo));
  dio_pin_model i_pins (.pin_out, .pin_oe, .ext_level, .pin_in);
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the answer and its error flag are taken at the edge where pready is seen.
  task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d, input logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= is_wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    chk({30'h0, pready, pslverr}, {30'h0, 1'b1, err});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err = 1'b0);
    apb(1'b0, a, 32'h0, err);
    chk(q, exp);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic test_reset;
    rd(OFS_LINE_DIR, 32'h0);
    rd(OFS_LINE_INV, 32'h0);
    rd(OFS_LINE_SRC, 32'h0);
    rd(OFS_UO_WORD, 32'h0);
    wr(OFS_LINE_SEL, LINE_OUT_ONLY);
    wr(OFS_LINE_DIR, 32'h0);
    rd(OFS_LINE_DIR, 32'h1);
    wr(OFS_LINE_SEL, LINE_IN_ONLY);
    wr(OFS_LINE_DIR, 32'h1);
    rd(OFS_LINE_DIR, 32'h0);
    chk({26'h0, pin_oe}, 32'h0);
    rd(8'h40, 32'h0, 1'b1);
    apb(1'b1, 8'h28, 32'h1, 1'b1);
    wr(OFS_LINE_SEL, 32'hc);
    rd(OFS_LINE_INV, 32'h0);
  endtask
  task automatic test_inputs;
    ext_level <= 5'h16;
    link      <= 2'h1;
    cc        <= 4'ha;
    repeat (8) @(posedge pclk);
    rd(OFS_LINE_ALL, {20'h0, 4'ha, 2'h1, 1'b0, 5'h16});
    wr(OFS_LINE_SEL, 32'h1);
    rd(OFS_LINE_LEVEL, 32'h1);
    wr(OFS_LINE_INV, 32'h1);
    rd(OFS_LINE_LEVEL, 32'h0);
    rd(OFS_LINE_ALL, {20'h0, 4'ha, 2'h1, 1'b0, 5'h14});
    wr(OFS_LINE_SEL, 32'h2);
    rd(OFS_LINE_INV, 32'h0);
  endtask
  task automatic test_output;
    timer <= 1'b1;
    wr(OFS_LINE_SRC, SRC_TIMER);
    repeat (3) @(posedge pclk);
    chk({26'h0, pin_oe}, 32'h0);
    wr(OFS_LINE_DIR, 32'h1);
    wr(OFS_LINE_INV, 32'h1);
    repeat (3) @(posedge pclk);
    chk({25'h0, pin_oe, pin_out[2]}, 32'h8);
    repeat (6) @(posedge pclk);
    rd(OFS_LINE_LEVEL, 32'h1);
    wr(OFS_LINE_SRC, SRC_EXPO);
    repeat (3) @(posedge pclk);
    chk({31'h0, pin_out[2]}, 32'h1);
    expo <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, pin_out[2]}, 32'h0);
    wr(OFS_LINE_SRC, SRC_OFF);
    repeat (3) @(posedge pclk);
    chk({26'h0, pin_oe}, 32'h0);
  endtask
  // A reset in mid-run must bring back the selector, line 3's direction and source, line 1's inversion, the soft word and its mask.
  task automatic test_rerun;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk({26'h0, pin_oe}, 32'h0);
    rd(OFS_LINE_SEL, 32'h0);
    wr(OFS_LINE_SEL, 32'h3);
    rd(OFS_LINE_DIR, 32'h0);
    rd(OFS_LINE_SRC, 32'h0);
    wr(OFS_LINE_SEL, 32'h1);
    rd(OFS_LINE_INV, 32'h0);
    rd(OFS_UO_WORD, 32'h0);
    rd(OFS_UO_MASK, 32'hff);
  endtask
  task automatic test_soft;
    wr(OFS_UO_PICK, 32'h3);
    wr(OFS_UO_VALUE, 32'h1);
    rd(OFS_UO_WORD, 32'h8);
    wr(OFS_UO_MASK, 32'h3c);
    wr(OFS_UO_WORD, 32'hff);
    rd(OFS_UO_WORD, 32'h3c);
    wr(OFS_UO_MASK, 32'hff);
    wr(OFS_LINE_SEL, 32'h3);
    wr(OFS_LINE_DIR, 32'h1);
    for (int b = 0; b < UO_W; b++)
    begin
      wr(OFS_UO_WORD, 32'h1 << b);
      wr(OFS_LINE_SRC, 32'(SRC_UO_BASE) + b);
      repeat (3) @(posedge pclk);
      chk({31'h0, pin_out[3]}, 32'h1);
      wr(OFS_UO_WORD, ~(32'h1 << b) & 32'hff);
      repeat (3) @(posedge pclk);
      chk({31'h0, pin_out[3]}, 32'h0);
    end
  endtask
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, timer, expo} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    ext_level = 5'h0;
    link = 2'h0;
    cc = 4'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_inputs();
    test_output();
    test_soft();
    test_rerun();
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    close_out();
  end
endmodule
